// file: verif/smc_irq_partner.sv
// interrupt source model feeding the wake inputs
`timescale 1ns/1ps
module smc_irq_partner (
	input  wire logic       clk_sys_in,
	input  wire logic       rstn_in,
	input  wire logic [2:0] fire_in,
	input  wire logic [3:0] delay_in,
	output logic            ext_irq_out,
	output logic            tbt_irq_out,
	output logic            watch_presc_irq_out
);
	logic [2:0] lvl_ff;
	logic [3:0] cnt_ff;
	// requests stand as levels until fire_in returns to zero
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lvl_ff <= 3'h0;
			cnt_ff <= 4'h0;
		end else if (fire_in == 3'h0) begin
			lvl_ff <= 3'h0;
			cnt_ff <= 4'h0;
		end else if (cnt_ff < delay_in) begin
			cnt_ff <= cnt_ff + 4'h1;
		end else begin
			lvl_ff <= fire_in;
		end
	end
	assign ext_irq_out = lvl_ff[0];
	assign tbt_irq_out = lvl_ff[1];
	assign watch_presc_irq_out = lvl_ff[2];
endmodule // smc_irq_partner

// file: verif/smc_standby_assertions.sv
// port-level checker for the standby mode controller
`timescale 1ns/1ps
module smc_standby_assertions
	import smc_pkg::*;
#(
	parameter int unsigned STAB_MAIN_OSC = 20,
	parameter int unsigned STAB_SUB      = 30
) (
	input wire logic        clk_sys_in,
	input wire logic        rstn_in,
	input wire logic [3:0]  avs_address_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0]  avs_byteenable_in,
	input wire logic        avs_waitrequest_out,
	input wire logic [1:0]  clock_mode_monitor_in,
	input wire logic        irq_hi_pend_in,
	input wire logic        wdt_standby_en_in,
	input wire logic        ext_irq_in,
	input wire logic        watch_presc_irq_in,
	input wire logic        main_osc_en_out,
	input wire logic        main_rc_en_out,
	input wire logic        sub_osc_en_out,
	input wire logic        sub_rc_en_out,
	input wire logic        cpu_clk_en_out,
	input wire logic        periph_clk_en_out,
	input wire logic        tbt_en_out,
	input wire logic        watch_presc_en_out,
	input wire logic        wdt_run_out,
	input wire logic        pin_hold_out,
	input wire logic        pin_hiz_out,
	input wire logic [2:0]  standby_state_out,
	input wire logic [1:0]  clock_mode_restore_out,
	input wire logic        wake_pulse_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	logic       acc;
	logic       sel_ff;
	logic [3:0] ext_hist_ff;
	logic [3:0] wp_hist_ff;
	logic [9:0] stab_cnt_ff;
	int         stab_need;
	assign acc = avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_STANDBY_CTRL && avs_byteenable_in[0];
	assign stab_need = clock_mode_monitor_in == CLK_MODE_MAIN_OSC ? STAB_MAIN_OSC :
		clock_mode_monitor_in == CLK_MODE_MAIN_RC ? 500 : STAB_SUB;
	// history covers the two-flop sync delay plus margin
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sel_ff <= 1'b0;
			ext_hist_ff <= 4'h0;
			wp_hist_ff <= 4'h0;
			stab_cnt_ff <= 10'h0;
		end else begin
			if (acc && !irq_hi_pend_in && standby_state_out == 3'h0)
				sel_ff <= avs_writedata_in[PIN_STATE_SELECT_BIT];
			ext_hist_ff <= {ext_hist_ff[2:0], ext_irq_in};
			wp_hist_ff <= {wp_hist_ff[2:0], watch_presc_irq_in};
			stab_cnt_ff <= (standby_state_out == 3'h5) ? stab_cnt_ff + 10'h1 : 10'h0;
		end
	end
	property p_stop_clks;
		standby_state_out == 3'h2 |-> !main_osc_en_out && !main_rc_en_out && !sub_osc_en_out && !cpu_clk_en_out
			&& !periph_clk_en_out && !tbt_en_out;
	endproperty
	a_stop_clks: assert property (p_stop_clks) else $error("stop left a clock running");
	property p_wdt;
		$past(wdt_standby_en_in) && standby_state_out inside {3'h2, 3'h3, 3'h4}
			|-> sub_rc_en_out && wdt_run_out && (standby_state_out != 3'h2 || watch_presc_en_out);
	endproperty
	a_wdt: assert property (p_wdt) else $error("standby watchdog clocks off");
	property p_entry;
		acc && avs_writedata_in[STOP_REQUEST_BIT] && !irq_hi_pend_in && standby_state_out == 3'h0
			|=> (standby_state_out == 3'h1) [*4] ##1 standby_state_out == 3'h2;
	endproperty
	a_entry: assert property (p_entry) else $error("stop entry timing wrong");
	property p_refuse;
		acc && (|avs_writedata_in[1:0]) && irq_hi_pend_in |=> (standby_state_out == 3'h0) [*3];
	endproperty
	a_refuse: assert property (p_refuse) else $error("entry taken with high request pending");
	property p_pins;
		standby_state_out inside {3'h2, 3'h3, 3'h4} |-> pin_hiz_out == sel_ff && pin_hold_out == !sel_ff;
	endproperty
	a_pins: assert property (p_pins) else $error("pin state wrong in standby");
	property p_tbt;
		standby_state_out == 3'h3 |-> main_osc_en_out && tbt_en_out && !cpu_clk_en_out && !periph_clk_en_out
			&& watch_presc_en_out == sub_osc_en_out;
	endproperty
	a_tbt: assert property (p_tbt) else $error("timer mode clocks wrong");
	property p_watch;
		standby_state_out == 3'h4 |-> !main_osc_en_out && !main_rc_en_out && !tbt_en_out && watch_presc_en_out
			&& !cpu_clk_en_out && !periph_clk_en_out;
	endproperty
	a_watch: assert property (p_watch) else $error("watch mode clocks wrong");
	property p_mode_sel;
		$past(standby_state_out) == 3'h1 && standby_state_out inside {3'h3, 3'h4}
			|-> (standby_state_out == 3'h3) == $past(clock_mode_monitor_in[1]);
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("wrong standby mode chosen");
	property p_stop_exit;
		standby_state_out == 3'h2 ##1 standby_state_out != 3'h2
			|-> standby_state_out == 3'h5 && (|ext_hist_ff || (|wp_hist_ff && wdt_standby_en_in));
	endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop left without a wake source");
	property p_stab;
		standby_state_out == 3'h5 ##1 standby_state_out == 3'h0
			|-> stab_cnt_ff == stab_need;
	endproperty
	a_stab: assert property (p_stab) else $error("stabilisation wait length wrong");
	property p_wake;
		$past(standby_state_out) inside {3'h3, 3'h4, 3'h5} && standby_state_out == 3'h0
			|-> wake_pulse_out && clock_mode_restore_out == clock_mode_monitor_in;
	endproperty
	a_wake: assert property (p_wake) else $error("wake pulse or restore mode wrong");
endmodule // smc_standby_assertions

bind smc_standby_ctrl smc_standby_assertions #(
	.STAB_MAIN_OSC(STAB_MAIN_OSC),
	.STAB_SUB(STAB_SUB)
) smc_standby_assertions_i (.*);

// file: verif/smc_standby_ctrl_tb_top.sv
// self-checking bench for the standby mode controller
`timescale 1ns/1ps
module smc_standby_ctrl_tb_top
	import smc_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [1:0]  mon = CLK_MODE_MAIN_RC;
	logic        pend = 1'b0;
	logic        wdt = 1'b0;
	logic [2:0]  fire = 3'h0;
	logic [3:0]  dly = 4'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic [2:0]  state;
	logic        ext;
	logic        tbt;
	logic        wp;
	logic [31:0] rd_q[$];
	logic [2:0]  st_q[$];
	logic [2:0]  st_prev = 3'h0;
	logic [31:0] e_rd;
	logic [2:0]  e_st;
	logic [31:0] seed = 32'h2E2C;
	int          error_cnt = 0;
	int          checks = 0;
	// {monitor, wdt, stop, ignored sources, waking source}; sources are {wp, tbt, ext}
	logic [9:0]  cases [8] = '{10'b11_0_1_110_001, 10'b10_1_1_010_100, 10'b00_0_1_000_001,
		10'b11_0_0_100_010, 10'b10_1_0_000_001, 10'b01_0_0_010_100, 10'b00_1_0_000_001, 10'b11_0_0_000_100};
	always #10 clk_sys = ~clk_sys;
	smc_standby_ctrl #(.STAB_MAIN_OSC(20), .STAB_SUB(30)) smc_standby_ctrl_i (
		.clk_sys_in(clk_sys), .rstn_in(rstn), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .clock_mode_monitor_in(mon), .irq_hi_pend_in(pend),
		.wdt_standby_en_in(wdt), .ext_irq_in(ext), .tbt_irq_in(tbt), .watch_presc_irq_in(wp),
		.main_osc_en_out(), .main_rc_en_out(), .sub_osc_en_out(), .sub_rc_en_out(), .cpu_clk_en_out(),
		.periph_clk_en_out(), .tbt_en_out(), .watch_presc_en_out(), .wdt_run_out(), .pin_hold_out(),
		.pin_hiz_out(), .standby_state_out(state), .clock_mode_restore_out(), .wake_pulse_out());
	smc_irq_partner smc_irq_partner_i (.clk_sys_in(clk_sys), .rstn_in(rstn), .fire_in(fire), .delay_in(dly),
		.ext_irq_out(ext), .tbt_irq_out(tbt), .watch_presc_irq_out(wp));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic fail(input string what, input logic [31:0] e, input logic [31:0] s);
		error_cnt++;
		$display("mismatch %s expected %h seen %h", what, e, s);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20) begin
			fail("waitrequest", 32'h0, 32'h1);
			end_of_test();
		end
		@(posedge clk_sys);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wait_st(input logic [2:0] s, input int lim);
		int n;
		for (n = 0; n < lim && state !== s; n++)
			@(posedge clk_sys);
		if (state !== s) begin
			fail("wait state", {29'h0, s}, {29'h0, state});
			end_of_test();
		end
	endtask
	task automatic run_case(input logic [9:0] c);
		logic [2:0] tgt;
		logic       sel;
		seed = xs(seed);
		sel = seed[0];
		tgt = c[6] ? 3'h2 : (c[9] ? 3'h3 : 3'h4);
		mon <= c[9:8];
		wdt <= c[7];
		dly <= seed[7:4];
		@(posedge clk_sys);
		st_q.push_back(3'h1);
		st_q.push_back(tgt);
		bus(1'b1, OFS_STANDBY_CTRL, {29'h0, sel, !c[6], c[6]});
		wait_st(tgt, 20);
		fire <= c[5:3];
		repeat (24) @(posedge clk_sys);
		// clear ignored sources so the recorded wake cause holds only the waking source
		fire <= 3'h0;
		if (c[6])
			st_q.push_back(3'h5);
		st_q.push_back(3'h0);
		@(posedge clk_sys);
		fire <= c[2:0];
		wait_st(3'h0, 700);
		fire <= 3'h0;
		rd_chk(OFS_STATUS, {19'h0, c[7], 2'h0, c[9:8], 1'b0, c[2:0], 4'h0});
	endtask
	always @(posedge clk_sys) begin
		if (rd && waitreq === 1'b0) begin
			checks++;
			e_rd = rd_q.size() != 0 ? rd_q.pop_front() : 32'hFFFF_FFFF;
			if (rdata !== e_rd)
				fail("readdata", e_rd, rdata);
		end
		if (rstn && state !== st_prev) begin
			checks++;
			e_st = st_q.size() != 0 ? st_q.pop_front() : 3'h7;
			if (state !== e_st)
				fail("state", {29'h0, e_st}, {29'h0, state});
		end
		st_prev = state;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail("timeout", 32'h0, 32'h1);
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd_chk(OFS_STANDBY_CTRL, 32'h0);
		rd_chk(OFS_SYS_CLK_CTRL2, 32'hA);
		rd_chk(4'hC, 32'h0);
		pend <= 1'b1;
		bus(1'b1, OFS_STANDBY_CTRL, 32'h1);
		repeat (8) @(posedge clk_sys);
		pend <= 1'b0;
		rd_chk(OFS_STATUS, 32'h200);
		// write without the low byte lane must leave pin select alone
		be <= 4'hE;
		bus(1'b1, OFS_STANDBY_CTRL, 32'h4);
		be <= 4'hF;
		rd_chk(OFS_STANDBY_CTRL, 32'h0);
		bus(1'b1, OFS_SYS_CLK_CTRL2, 32'hC);
		rd_chk(OFS_SYS_CLK_CTRL2, 32'hE);
		bus(1'b1, OFS_SYS_CLK_CTRL2, 32'h8);
		foreach (cases[i]) begin
			// last case needs the sub oscillator on so the prescaler can wake timer mode
			if (i == 7)
				bus(1'b1, OFS_SYS_CLK_CTRL2, 32'hC);
			run_case(cases[i]);
		end
		end_of_test();
	end
endmodule // smc_standby_ctrl_tb_top

// file: verilog/smc_pkg.sv
// shared constants and types for the standby mode controller
package smc_pkg;
	localparam int unsigned CLK_FREQ_MHZ          = 50;

	// register byte offsets
	localparam logic [3:0]  OFS_STANDBY_CTRL      = 4'h0;
	localparam logic [3:0]  OFS_SYS_CLK_CTRL2     = 4'h4;
	localparam logic [3:0]  OFS_STATUS            = 4'h8;

	// standby_control_reg fields
	localparam int unsigned STOP_REQUEST_BIT      = 0;
	localparam int unsigned WATCH_REQUEST_BIT     = 1;
	localparam int unsigned PIN_STATE_SELECT_BIT  = 2;

	// system_clock_control_reg2 fields
	localparam int unsigned CLOCK_MODE_MONITOR_LO = 0;
	localparam int unsigned CLOCK_MODE_MONITOR_HI = 1;
	localparam int unsigned SUB_OSC_ENABLE_BIT    = 2;
	localparam int unsigned SUB_RC_OSC_ENABLE_BIT = 3;

	// status register fields
	localparam int unsigned STAT_STATE_LSB        = 0;
	localparam int unsigned STAT_WAKE_LSB         = 4;
	localparam int unsigned STAT_RESTORE_LSB      = 8;
	localparam int unsigned STAT_WDT_STBY         = 12;

	// clock mode codes as seen on the monitor bits
	localparam logic [1:0]  CLK_MODE_SUB_RC       = 2'h0;
	localparam logic [1:0]  CLK_MODE_SUB_OSC      = 2'h1;
	localparam logic [1:0]  CLK_MODE_MAIN_RC      = 2'h2;
	localparam logic [1:0]  CLK_MODE_MAIN_OSC     = 2'h3;

	// reset values
	localparam logic [1:0]  CLK_MODE_RST          = CLK_MODE_MAIN_RC;
	localparam logic        PIN_SEL_RST           = 1'b0;
	localparam logic        SUB_OSC_EN_RST        = 1'b0;
	localparam logic        SUB_RC_EN_RST         = 1'b1;

	// timing
	localparam int unsigned ENTRY_DELAY_CYC       = 4;
	localparam int unsigned STAB_MAIN_OSC_US      = 200;
	localparam int unsigned STAB_MAIN_RC_US       = 10;
	localparam int unsigned STAB_SUB_US           = 1000;
	localparam int unsigned STAB_MAIN_OSC_CYC     = STAB_MAIN_OSC_US * CLK_FREQ_MHZ;
	localparam int unsigned STAB_MAIN_RC_CYC      = STAB_MAIN_RC_US * CLK_FREQ_MHZ;
	localparam int unsigned STAB_SUB_CYC          = STAB_SUB_US * CLK_FREQ_MHZ;
	localparam int unsigned CNT_W                 = 16;

	// enable vector positions
	localparam int unsigned EN_MAIN_OSC           = 0;
	localparam int unsigned EN_MAIN_RC            = 1;
	localparam int unsigned EN_SUB_OSC            = 2;
	localparam int unsigned EN_SUB_RC             = 3;
	localparam int unsigned EN_CPU_CLK            = 4;
	localparam int unsigned EN_PERIPH_CLK         = 5;
	localparam int unsigned EN_TBT                = 6;
	localparam int unsigned EN_WATCH_PRESC        = 7;
	localparam int unsigned EN_WDT                = 8;
	localparam int unsigned EN_PIN_HOLD           = 9;
	localparam int unsigned EN_PIN_HIZ            = 10;
	localparam int unsigned EN_W                  = 11;
	localparam logic [10:0] EN_RST                = 11'h1FB;

	typedef enum logic [2:0] {
		SMC_RUN,
		SMC_ENTRY,
		SMC_STOP,
		SMC_TBT,
		SMC_WATCH,
		SMC_STAB
	} smc_state_t;
endpackage

// file: verilog/smc_standby_ctrl.sv
// standby mode sequencer with avalon-mm register slave
// Function
// RQ1 - stop mode halts main oscillator, main rc and sub oscillator clocks.
// RQ2 - stop keeps registers and ram, only external interrupt and lvd reset live.
// RQ3 - watchdog enabled in standby keeps sub rc clock and watchdog running.
// RQ4 - writing one to the stop request bit enters stop mode.
// RQ5 - pin select zero holds pins, one floats them in every standby mode.
// RQ6 - stop is left only on reset or external interrupt; code also leaves it on watch prescaler interrupt with standby watchdog.
// RQ7 - with standby watchdog, watch prescaler runs in stop and its interrupt wakes.
// RQ8 - software should mask time-base timer interrupts before stop from main modes.
// RQ9 - software should mask watch prescaler interrupts before stop from sub modes.
// RQ10 - after interrupt wake peripherals resume where paused; software reinitialises them.
// RQ11 - time-base timer mode runs only oscillators, timer and prescaler; cpu stopped.
// RQ12 - in time-base timer mode sub clocks follow enables; prescaler follows sub oscillator.
// RQ13 - watch request in main clock modes enters time-base timer mode.
// RQ14 - time-base timer mode left on reset, timer, external or prescaler interrupt.
// RQ15 - watch mode runs only sub clocks and watch prescaler; cpu stopped.
// RQ16 - watch request in sub clock modes enters watch mode.
// RQ17 - watch mode left on reset, watch prescaler or external interrupt.
// RQ18 - standby starts four machine cycles after the control write.
// RQ19 - pending high-level request cancels entry; high requests wake regardless of masking.
// RQ20 - reset returns to main rc mode; interrupt returns to previous clock mode.
// RQ21 - external wake from stop waits the current mode's stabilisation time.
`timescale 1ns/1ps
module smc_standby_ctrl
	import smc_pkg::*;
#(
	parameter int unsigned STAB_MAIN_OSC = STAB_MAIN_OSC_CYC,
	parameter int unsigned STAB_SUB      = STAB_SUB_CYC
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic [1:0]  clock_mode_monitor_in,
	input  wire logic        irq_hi_pend_in,
	input  wire logic        wdt_standby_en_in,
	input  wire logic        ext_irq_in,
	input  wire logic        tbt_irq_in,
	input  wire logic        watch_presc_irq_in,
	output logic             main_osc_en_out,
	output logic             main_rc_en_out,
	output logic             sub_osc_en_out,
	output logic             sub_rc_en_out,
	output logic             cpu_clk_en_out,
	output logic             periph_clk_en_out,
	output logic             tbt_en_out,
	output logic             watch_presc_en_out,
	output logic             wdt_run_out,
	output logic             pin_hold_out,
	output logic             pin_hiz_out,
	output logic [2:0]       standby_state_out,
	output logic [1:0]       clock_mode_restore_out,
	output logic             wake_pulse_out
);
	initial begin
		if (STAB_MAIN_OSC < 1 || STAB_MAIN_OSC >= (1 << CNT_W)) begin
			$error("smc_standby_ctrl: STAB_MAIN_OSC out of range");
		end
		if (STAB_SUB < 1 || STAB_SUB >= (1 << CNT_W)) begin
			$error("smc_standby_ctrl: STAB_SUB out of range");
		end
	end

	logic             bus_req;
	logic             ack_ff;
	logic             wr_take;
	logic             stby_wr;
	logic             clk2_wr;
	logic             stop_wr;
	logic             watch_wr;
	logic             entry_ok;
	logic [31:0]      nxt_readdata;
	logic [31:0]      readdata_ff;
	logic             pin_sel_ff;
	logic             sub_osc_bit_ff;
	logic             sub_rc_bit_ff;
	logic [2:0]       irq_sync;
	logic             ext_irq;
	logic             tbt_irq;
	logic             wp_irq;
	smc_state_t       state_ff;
	smc_state_t       nxt_state;
	smc_state_t       target_ff;
	smc_state_t       nxt_target;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [1:0]       saved_mode_ff;
	logic [1:0]       restore_ff;
	logic [2:0]       wake_cause_ff;
	logic             wake_ff;
	logic             int_wake;
	logic [EN_W-1:0]  nxt_en;
	logic [EN_W-1:0]  en_ff;
	logic             mode_is_main;
	logic             stop_wake;
	logic             tbt_wake;
	logic             watch_wake;

	// interrupt lines come from peripherals on their own clocks
	smc_sync2 #(
		.WIDTH(3)
	) u_irq_sync (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.async_in   ({watch_presc_irq_in, tbt_irq_in, ext_irq_in}),
		.sync_out   (irq_sync)
	);

	assign ext_irq = irq_sync[0];
	assign tbt_irq = irq_sync[1];
	assign wp_irq  = irq_sync[2];

	// one wait state on every access
	assign bus_req             = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_req & ~ack_ff;
	assign avs_readdata_out    = readdata_ff;
	assign wr_take             = avs_write_in & ack_ff & avs_byteenable_in[0];
	assign stby_wr             = wr_take && (avs_address_in == OFS_STANDBY_CTRL);
	assign clk2_wr             = wr_take && (avs_address_in == OFS_SYS_CLK_CTRL2);
	assign stop_wr             = stby_wr & avs_writedata_in[STOP_REQUEST_BIT];
	assign watch_wr            = stby_wr & avs_writedata_in[WATCH_REQUEST_BIT];
	// write is dropped while a high-level request is pending
	assign entry_ok            = (stop_wr | watch_wr) && (state_ff == SMC_RUN) && !irq_hi_pend_in; // RQ19

	assign mode_is_main        = clock_mode_monitor_in[CLOCK_MODE_MONITOR_HI];

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
		end
	end

	always_comb begin
		nxt_readdata = '0;
		unique case (avs_address_in)
			OFS_STANDBY_CTRL: begin
				nxt_readdata[PIN_STATE_SELECT_BIT] = pin_sel_ff;
			end
			OFS_SYS_CLK_CTRL2: begin
				nxt_readdata[CLOCK_MODE_MONITOR_HI] = clock_mode_monitor_in[1];
				nxt_readdata[CLOCK_MODE_MONITOR_LO] = clock_mode_monitor_in[0];
				nxt_readdata[SUB_OSC_ENABLE_BIT]    = sub_osc_bit_ff;
				nxt_readdata[SUB_RC_OSC_ENABLE_BIT] = sub_rc_bit_ff;
			end
			OFS_STATUS: begin
				nxt_readdata[STAT_STATE_LSB +: 3]   = 3'(state_ff);
				nxt_readdata[STAT_WAKE_LSB +: 3]    = wake_cause_ff;
				nxt_readdata[STAT_RESTORE_LSB +: 2] = restore_ff;
				nxt_readdata[STAT_WDT_STBY]         = wdt_standby_en_in;
			end
			default: begin
				nxt_readdata = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			readdata_ff <= '0;
		end else if (bus_req & ~ack_ff) begin
			readdata_ff <= nxt_readdata;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_sel_ff <= PIN_SEL_RST;
		end else if (stby_wr && (state_ff == SMC_RUN) && !irq_hi_pend_in) begin // RQ19
			pin_sel_ff <= avs_writedata_in[PIN_STATE_SELECT_BIT];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sub_osc_bit_ff <= SUB_OSC_EN_RST;
			sub_rc_bit_ff  <= SUB_RC_EN_RST;
		end else if (clk2_wr) begin
			sub_osc_bit_ff <= avs_writedata_in[SUB_OSC_ENABLE_BIT];
			sub_rc_bit_ff  <= avs_writedata_in[SUB_RC_OSC_ENABLE_BIT];
		end
	end

	// wake sources are taken straight, the cpu mask is not consulted
	assign stop_wake  = ext_irq | (wdt_standby_en_in & wp_irq); // RQ6 RQ7 RQ19
	assign tbt_wake   = ext_irq | tbt_irq | (sub_osc_bit_ff & wp_irq); // RQ14
	assign watch_wake = ext_irq | wp_irq; // RQ17

	always_comb begin
		nxt_target = target_ff;
		if (entry_ok) begin
			if (stop_wr) begin
				nxt_target = SMC_STOP; // RQ4
			end else if (mode_is_main) begin
				nxt_target = SMC_TBT; // RQ13
			end else begin
				nxt_target = SMC_WATCH; // RQ16
			end
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		unique case (state_ff)
			SMC_RUN: begin
				if (entry_ok) begin
					nxt_state = SMC_ENTRY;
					nxt_cnt   = CNT_W'(ENTRY_DELAY_CYC - 1); // RQ18
				end
			end
			SMC_ENTRY: begin
				// cpu still runs here, so a late high request can still cancel
				if (irq_hi_pend_in) begin
					nxt_state = SMC_RUN; // RQ19
				end else if (cnt_ff == '0) begin
					nxt_state = target_ff; // RQ18
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			SMC_STOP: begin
				if (stop_wake) begin
					nxt_state = SMC_STAB; // RQ21
					unique case (saved_mode_ff)
						CLK_MODE_MAIN_OSC: nxt_cnt = CNT_W'(STAB_MAIN_OSC - 1);
						CLK_MODE_MAIN_RC:  nxt_cnt = CNT_W'(STAB_MAIN_RC_CYC - 1);
						CLK_MODE_SUB_OSC:  nxt_cnt = CNT_W'(STAB_SUB - 1);
						CLK_MODE_SUB_RC:   nxt_cnt = CNT_W'(STAB_SUB - 1);
					endcase
				end
			end
			SMC_STAB: begin
				if (cnt_ff == '0) begin
					nxt_state = SMC_RUN; // RQ21
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			SMC_TBT: begin
				if (tbt_wake) begin
					nxt_state = SMC_RUN; // RQ14
				end
			end
			SMC_WATCH: begin
				if (watch_wake) begin
					nxt_state = SMC_RUN; // RQ17
				end
			end
			default: begin
				nxt_state = SMC_RUN;
				nxt_cnt   = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff  <= SMC_RUN;
			target_ff <= SMC_STOP;
			cnt_ff    <= '0;
		end else begin
			state_ff  <= nxt_state;
			target_ff <= nxt_target;
			cnt_ff    <= nxt_cnt;
		end
	end

	// the mode is caught at the accepted write, before the clock controller moves
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			saved_mode_ff <= CLK_MODE_RST;
		end else if (entry_ok) begin
			saved_mode_ff <= clock_mode_monitor_in;
		end
	end

	assign int_wake = (state_ff == SMC_TBT || state_ff == SMC_WATCH || state_ff == SMC_STAB)
		&& (nxt_state == SMC_RUN);

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			restore_ff <= CLK_MODE_RST; // RQ20
			wake_ff    <= 1'b0;
		end else begin
			wake_ff <= int_wake;
			if (int_wake) begin
				restore_ff <= saved_mode_ff; // RQ20
			end
		end
	end

	// cause bits: external, time-base timer, watch prescaler
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wake_cause_ff <= '0;
		end else if (entry_ok) begin
			wake_cause_ff <= '0;
		end else if ((state_ff == SMC_STOP && stop_wake) || (state_ff == SMC_TBT && tbt_wake)
			|| (state_ff == SMC_WATCH && watch_wake)) begin
			wake_cause_ff <= {wp_irq, tbt_irq, ext_irq};
		end
	end

	always_comb begin
		nxt_en = '0;
		unique case (nxt_state)
			SMC_RUN, SMC_ENTRY, SMC_STAB: begin
				nxt_en[EN_MAIN_OSC]    = 1'b1;
				nxt_en[EN_MAIN_RC]     = 1'b1;
				nxt_en[EN_SUB_OSC]     = sub_osc_bit_ff;
				nxt_en[EN_SUB_RC]      = sub_rc_bit_ff | wdt_standby_en_in;
				nxt_en[EN_TBT]         = 1'b1;
				nxt_en[EN_WATCH_PRESC] = 1'b1;
				// clocks simply resume, peripheral state is never reset here
				nxt_en[EN_CPU_CLK]     = (nxt_state != SMC_STAB); // RQ10
				nxt_en[EN_PERIPH_CLK]  = (nxt_state != SMC_STAB); // RQ10
				nxt_en[EN_WDT]         = (nxt_state != SMC_STAB) | wdt_standby_en_in; // RQ3
			end
			SMC_STOP: begin
				// main and sub oscillators off, sub rc only for the standby watchdog; ram and registers keep their value without a clock
				nxt_en[EN_SUB_RC]      = wdt_standby_en_in; // RQ1 RQ2 RQ3
				nxt_en[EN_WDT]         = wdt_standby_en_in; // RQ3
				nxt_en[EN_WATCH_PRESC] = wdt_standby_en_in; // RQ7
			end
			SMC_TBT: begin
				nxt_en[EN_MAIN_OSC]    = 1'b1; // RQ11
				nxt_en[EN_TBT]         = 1'b1; // RQ11
				nxt_en[EN_SUB_OSC]     = sub_osc_bit_ff; // RQ12
				nxt_en[EN_SUB_RC]      = sub_rc_bit_ff | wdt_standby_en_in; // RQ12 RQ3
				nxt_en[EN_WATCH_PRESC] = sub_osc_bit_ff; // RQ12
				nxt_en[EN_WDT]         = wdt_standby_en_in; // RQ3
			end
			SMC_WATCH: begin
				nxt_en[EN_SUB_OSC]     = sub_osc_bit_ff; // RQ15
				nxt_en[EN_SUB_RC]      = sub_rc_bit_ff | wdt_standby_en_in; // RQ15 RQ3
				nxt_en[EN_WATCH_PRESC] = 1'b1; // RQ15
				nxt_en[EN_WDT]         = wdt_standby_en_in; // RQ3
			end
		endcase
		if (nxt_state == SMC_STOP || nxt_state == SMC_TBT || nxt_state == SMC_WATCH || nxt_state == SMC_STAB) begin
			nxt_en[EN_PIN_HOLD] = ~pin_sel_ff; // RQ5
			nxt_en[EN_PIN_HIZ]  = pin_sel_ff; // RQ5
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			en_ff <= EN_RST;
		end else begin
			en_ff <= nxt_en;
		end
	end

	assign main_osc_en_out        = en_ff[EN_MAIN_OSC];
	assign main_rc_en_out         = en_ff[EN_MAIN_RC];
	assign sub_osc_en_out         = en_ff[EN_SUB_OSC];
	assign sub_rc_en_out          = en_ff[EN_SUB_RC];
	assign cpu_clk_en_out         = en_ff[EN_CPU_CLK];
	assign periph_clk_en_out      = en_ff[EN_PERIPH_CLK];
	assign tbt_en_out             = en_ff[EN_TBT];
	assign watch_presc_en_out     = en_ff[EN_WATCH_PRESC];
	assign wdt_run_out            = en_ff[EN_WDT];
	assign pin_hold_out           = en_ff[EN_PIN_HOLD];
	assign pin_hiz_out            = en_ff[EN_PIN_HIZ];
	assign standby_state_out      = 3'(state_ff);
	assign clock_mode_restore_out = restore_ff;
	assign wake_pulse_out         = wake_ff;
endmodule // smc_standby_ctrl

// file: verilog/smc_sync2.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module smc_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rstn_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	initial begin
		if (WIDTH < 1) begin
			$error("smc_sync2: WIDTH must be at least 1");
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // smc_sync2
